// ===== design/pbdc_ctrl.sv
// PCI DMA backend control: launch hold, side register port, direct DMA.
`timescale 1ns/1ns
`default_nettype none
`include "pbdc_defines.svh"
module pbdc_ctrl (
  input wire logic i_sys_clk, // System clock, 10 MHz.
  input wire logic i_srst, // Synchronous reset, active high.
  input wire pbdc_pkg::pbdc_pin_t i_pin, // Raw grant, target ready, AD in.
  output logic o_req_n, // PCI bus request, active low.
  output logic o_frame_n, // FRAME# level.
  output logic o_frame_oe_n, // FRAME# drive enable, low drives.
  output logic o_irdy_n, // IRDY# level.
  output logic o_irdy_oe_n, // IRDY# drive enable, low drives.
  output logic [31:0] o_ad, // AD bus out.
  output logic o_ad_oe_n, // AD and C/BE drive enable, low drives.
  output logic [3:0] o_cbe_n, // Command and byte enables.
  input wire logic i_tgt_access, // Target decoder hit on this device.
  output logic o_tgt_retry, // Answer the target hit with retry.
  output logic o_mast_active, // Master cycle in progress.
  output logic o_datapath_begin, // Backend transfer begins.
  output logic o_datapath_finish, // Backend transfer ends or aborts.
  output logic [2:0] o_window_sel, // Memory window in use.
  output logic o_be_wr_strobe, // Received word valid on data out.
  input wire logic i_launch_hold, // Backend holds off the launch.
  input wire logic i_rd_strobe, // Backend supplies a word.
  input wire logic i_backend_write_ready, // Backend can take a word.
  input wire logic i_side_request, // Backend asks for the side port.
  output logic o_side_grant, // Side port granted.
  input wire pbdc_pkg::pbdc_side_t i_side, // Side port strobes and address.
  input wire logic [31:0] i_mem_data_in, // Backend write data.
  output logic [31:0] o_mem_data_out // Backend read data.
);
  import pbdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  localparam int IDX_DATA = `PBDC_IDX_DATA; // Data word index.
  localparam int IDX_CTRL = `PBDC_IDX_CTRL; // Control word index.
  localparam logic [7:0] OFFS [4] = '{`PBDC_REG_PCI_ADDR, `PBDC_REG_DATA,
                                      `PBDC_REG_COUNT, `PBDC_REG_CTRL};
  pbdc_pin_t pin_s; // Synchronised pins.
  pbdc_state_t st_ff; // Sequencer state.
  logic [3:0][31:0] regs_w; // Register words.
  pbdc_ctrl_t ctrl; // Control word view.
  logic busy_ff; // A transfer is queued or running.
  logic [`PBDC_REQ_DLY-2:0] start_sr_ff; // Start delay line.
  logic data_ok_ff; // Word for the data phase is in hand.
  logic [31:0] data_ff; // Word to send or word received.
  logic [4:0] gnt_cnt_ff; // Cycles since grant while starting.
  logic aborted_ff; // A start was aborted and not yet relaunched.
  logic rd_valid_ff; // Side read in the first pipeline stage.
  logic [31:0] rd_stage_ff; // Side read data, first stage.
  logic start_wr; // Control write that launches a transfer.
  logic early; // Startup window before frame.
  logic abort; // Grant lost in the startup window.
  logic force_go; // Launch forced by the grant timer.
  logic launch_ok; // Hold released and ready to launch.
  logic fetch; // Backend data may be fetched now.
  logic data_go; // Start the single data phase.
  logic data_done; // Target accepted the data phase.

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  pbdc_sync #(.WIDTH($bits(pbdc_pin_t))) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_d(i_pin),
    .o_q(pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file, one byte flop per register and byte lane.
  // A DMA store into the data word wins over a software write.
  for (genvar r = 0; r < 4; r++) begin : g_reg
    for (genvar b = 0; b < 4; b++) begin : g_byte
      logic [7:0] b_ff; // One register byte.
      always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
          b_ff <= `PBDC_BYTE_RESET;
        end else if (r == IDX_DATA && st_ff == PBDC_FINISH && ctrl.direct && ctrl.pci_read) begin
          b_ff <= data_ff[8*b +: 8];
        end else if (o_side_grant && i_side.side_write_strobe[b] &&
                     i_side.side_reg_addr == OFFS[r]) begin
          b_ff <= i_mem_data_in[8*b +: 8];
        end
      end
      assign regs_w[r][8*b +: 8] = b_ff;
    end
  end
  assign ctrl = pbdc_ctrl_t'(regs_w[IDX_CTRL]);

  ////////////////////////////////////////////////////////////////////////////
  // Decode of sequencer conditions.
  always_comb begin
    start_wr = o_side_grant && i_side.side_write_strobe[0] && !busy_ff &&
               i_side.side_reg_addr == `PBDC_REG_CTRL && i_mem_data_in[0];
    early = st_ff == PBDC_BEGIN || st_ff == PBDC_HOLD;
    abort = early && pin_s.gnt_n;
    force_go = gnt_cnt_ff >= `PBDC_FRAME_FORCE;
    launch_ok = (!i_launch_hold && (!ctrl.hold_mode || data_ok_ff)) || force_go;
    fetch = early || st_ff == PBDC_LAUNCH || st_ff == PBDC_DATA;
    data_go = st_ff == PBDC_DATA && o_irdy_n && data_ok_ff;
    data_done = st_ff == PBDC_DATA && !o_irdy_n && !pin_s.trdy_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start delay line and busy flag; a start written while busy is ignored, not queued.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      start_sr_ff <= '0;
      busy_ff <= 1'b0;
    end else begin
      start_sr_ff <= {start_sr_ff[`PBDC_REQ_DLY-3:0], start_wr};
      if (start_wr) begin
        busy_ff <= 1'b1;
      end else if (st_ff == PBDC_FINISH) begin
        busy_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      st_ff <= PBDC_IDLE;
    end else begin
      case (st_ff)
        PBDC_IDLE: begin
          if (start_sr_ff[`PBDC_REQ_DLY-2]) begin
            st_ff <= PBDC_REQ;
          end
        end
        PBDC_REQ: begin
          // Granted again after an abort restarts the same cycle.
          if (!pin_s.gnt_n) begin
            st_ff <= PBDC_ACT;
          end
        end
        PBDC_ACT: st_ff <= PBDC_BEGIN;
        PBDC_BEGIN: st_ff <= abort ? PBDC_REQ : PBDC_HOLD;
        PBDC_HOLD: begin
          if (abort) begin
            st_ff <= PBDC_REQ;
          end else if (launch_ok) begin
            st_ff <= PBDC_LAUNCH;
          end
        end
        PBDC_LAUNCH: st_ff <= PBDC_DATA;
        PBDC_DATA: begin
          if (data_done) begin
            st_ff <= PBDC_FINISH;
          end
        end
        PBDC_FINISH: st_ff <= PBDC_IDLE;
        default: st_ff <= PBDC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Grant timer and abort memory.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      gnt_cnt_ff <= 5'h00;
      aborted_ff <= 1'b0;
    end else begin
      if (st_ff == PBDC_IDLE || st_ff == PBDC_REQ || pin_s.gnt_n) begin
        gnt_cnt_ff <= 5'h00;
      end else if (!force_go) begin
        gnt_cnt_ff <= gnt_cnt_ff + 5'h01;
      end
      if (abort) begin
        aborted_ff <= 1'b1;
      end else if (st_ff == PBDC_LAUNCH) begin
        aborted_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PCI pin drive: request, frame, ready, address and data.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_req_n <= 1'b1;
      o_frame_n <= 1'b1;
      o_frame_oe_n <= 1'b1;
      o_irdy_n <= 1'b1;
      o_irdy_oe_n <= 1'b1;
      o_ad <= 32'h0000_0000;
      o_ad_oe_n <= 1'b1;
      o_cbe_n <= 4'hF;
    end else begin
      // Request stays low across aborts and drops only with frame.
      if (st_ff == PBDC_IDLE && start_sr_ff[`PBDC_REQ_DLY-2]) begin
        o_req_n <= 1'b0;
      end else if (st_ff == PBDC_LAUNCH) begin
        o_req_n <= 1'b1;
      end
      if (st_ff == PBDC_LAUNCH) begin
        o_frame_n <= 1'b0;
        o_frame_oe_n <= 1'b0;
        o_irdy_oe_n <= 1'b0;
      end else if (data_go) begin
        o_frame_n <= 1'b1; // Single data phase ends frame at once.
      end else if (st_ff == PBDC_FINISH) begin
        o_frame_oe_n <= 1'b1;
        o_irdy_oe_n <= 1'b1;
      end
      if (data_go) begin
        o_irdy_n <= 1'b0;
      end else if (data_done) begin
        o_irdy_n <= 1'b1;
      end
      // Address and command go on the bus with mast active.
      if (st_ff == PBDC_ACT) begin
        o_ad <= regs_w[0];
        o_ad_oe_n <= 1'b0;
        o_cbe_n <= ctrl.pci_read ? `PBDC_CMD_MEM_RD : `PBDC_CMD_MEM_WR;
      end else if (data_go) begin
        o_ad <= data_ff;
        o_ad_oe_n <= ctrl.pci_read;
        o_cbe_n <= `PBDC_BE_ALL_N;
      end else if (abort || data_done) begin
        o_ad_oe_n <= 1'b1;
        o_cbe_n <= 4'hF;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Backend handshake outputs.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_mast_active <= 1'b0;
      o_datapath_begin <= 1'b0;
      o_datapath_finish <= 1'b0;
      o_window_sel <= 3'h0;
      o_be_wr_strobe <= 1'b0;
    end else begin
      if (st_ff == PBDC_ACT) begin
        o_mast_active <= 1'b1;
      end else if (abort || st_ff == PBDC_FINISH) begin
        o_mast_active <= 1'b0;
      end
      // Begin trails mast active by one cycle so the backend can raise its hold with it.
      o_datapath_begin <= st_ff == PBDC_BEGIN;
      o_datapath_finish <= abort || data_done;
      if (st_ff == PBDC_ACT) begin
        o_window_sel <= ctrl.direct ? `PBDC_WIN_DIRECT : ctrl.win;
      end
      o_be_wr_strobe <= data_done && ctrl.pci_read && !ctrl.direct;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data word fetch and capture.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      data_ok_ff <= 1'b0;
      data_ff <= 32'h0000_0000;
    end else begin
      if (st_ff == PBDC_IDLE) begin
        data_ok_ff <= 1'b0;
      end else if (abort) begin
        data_ok_ff <= data_ok_ff && ctrl.fifo_recov;
      end else if (fetch && !data_ok_ff) begin
        if (ctrl.direct) begin
          data_ok_ff <= 1'b1;
        end else if (ctrl.pci_read) begin
          data_ok_ff <= i_backend_write_ready;
        end else begin
          data_ok_ff <= i_rd_strobe;
        end
      end
      if (fetch && !data_ok_ff && !ctrl.pci_read) begin
        if (ctrl.direct) begin
          data_ff <= regs_w[IDX_DATA];
        end else if (i_rd_strobe) begin
          data_ff <= i_mem_data_in;
        end
      end else if (data_done && ctrl.pci_read) begin
        data_ff <= pin_s.ad;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Side port grant, target retry and read pipeline.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_side_grant <= 1'b0;
      o_tgt_retry <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_stage_ff <= 32'h0000_0000;
      o_mem_data_out <= 32'h0000_0000;
    end else begin
      if (!i_side_request) begin
        o_side_grant <= 1'b0;
      end else if (st_ff == PBDC_IDLE && start_sr_ff == '0) begin
        o_side_grant <= 1'b1;
      end
      o_tgt_retry <= i_tgt_access && o_side_grant;
      rd_valid_ff <= o_side_grant && i_side.side_read_strobe;
      rd_stage_ff <= 32'h0000_0000;
      for (int r = 0; r < 4; r++) begin
        if (i_side.side_reg_addr == OFFS[r]) begin
          rd_stage_ff <= regs_w[r];
        end
      end
      if (i_side.side_reg_addr == `PBDC_REG_CTRL) begin
        rd_stage_ff <= regs_w[IDX_CTRL] | (32'(busy_ff) << `PBDC_BUSY_BIT);
      end
      if (rd_valid_ff) begin
        o_mem_data_out <= rd_stage_ff;
      end else if (data_done && ctrl.pci_read && !ctrl.direct) begin
        o_mem_data_out <= pin_s.ad;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  a_req_delay: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    start_wr |-> ##3 !o_req_n) else $error("request not three cycles after start");
  a_frame_release: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (st_ff == PBDC_HOLD && !abort && !i_launch_hold && !ctrl.hold_mode) |-> ##2 !o_frame_n)
    else $error("frame not two cycles after hold release");
  a_hold_blocks: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (st_ff == PBDC_HOLD && i_launch_hold && !force_go) |=> o_frame_n)
    else $error("frame asserted while held");
  a_irdy_delay: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (st_ff == PBDC_DATA && !data_ok_ff && !ctrl.direct && !ctrl.pci_read && i_rd_strobe)
    |-> ##2 !o_irdy_n) else $error("ready not two cycles after strobe");
  a_abort_finish: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    abort |=> o_datapath_finish && !o_mast_active && o_frame_n)
    else $error("abort without finish");
  a_recov_keep: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (abort && ctrl.fifo_recov && data_ok_ff) |=> data_ok_ff)
    else $error("recovery data dropped");
  a_req_held: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    aborted_ff |-> !o_req_n) else $error("request dropped after abort");
  a_grant_timer: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (st_ff == PBDC_HOLD && force_go && !abort) |-> ##2 !o_frame_n)
    else $error("forced launch late");
  a_retry_grant: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (i_tgt_access && o_side_grant) |=> o_tgt_retry) else $error("no retry while granted");
  a_grant_drop: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    !i_side_request |=> !o_side_grant) else $error("grant kept without request");
  a_read_pipe: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (o_side_grant && i_side.side_read_strobe && i_side.side_reg_addr == `PBDC_REG_DATA &&
     !(st_ff == PBDC_FINISH && ctrl.direct && ctrl.pci_read))
    |-> ##2 o_mem_data_out == $past(regs_w[IDX_DATA], 2)) else $error("read data late");
  a_window_direct: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (o_datapath_begin && ctrl.direct) |-> o_window_sel == 3'h7)
    else $error("window select wrong in direct mode");
endmodule : pbdc_ctrl
`default_nettype wire

// ===== design/pbdc_defines.svh
// Constants for the PCI DMA backend control block.
`ifndef PBDC_DEFINES_SVH
`define PBDC_DEFINES_SVH
// Side port register byte offsets.
`define PBDC_REG_PCI_ADDR 8'h50
`define PBDC_REG_DATA 8'h54
`define PBDC_REG_COUNT 8'h58
`define PBDC_REG_CTRL 8'h5C
// Register indices of the data word and the control word.
`define PBDC_IDX_DATA 1
`define PBDC_IDX_CTRL 3
// Reset value of every register byte.
`define PBDC_BYTE_RESET 8'h00
// Bit position where the busy flag reads back in the control word.
`define PBDC_BUSY_BIT 8
// Cycles from control write to bus request.
`define PBDC_REQ_DLY 3
// Longest grant-to-frame delay in cycles, and the earlier forced launch.
`define PBDC_FRAME_MAX 16
`define PBDC_FRAME_FORCE (5'(`PBDC_FRAME_MAX - 4))
// Window select value used by direct transfers.
`define PBDC_WIN_DIRECT 3'h7
// PCI bus commands and byte enables.
`define PBDC_CMD_MEM_RD 4'h6
`define PBDC_CMD_MEM_WR 4'h7
`define PBDC_BE_ALL_N 4'h0
`endif

// ===== design/pbdc_pkg.sv
// Types shared by the PCI DMA backend control block.
package pbdc_pkg;
  // Transfer sequencer states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    PBDC_IDLE = 3'h0,
    PBDC_REQ = 3'h1,
    PBDC_ACT = 3'h3,
    PBDC_BEGIN = 3'h2,
    PBDC_HOLD = 3'h6,
    PBDC_LAUNCH = 3'h7,
    PBDC_DATA = 3'h5,
    PBDC_FINISH = 3'h4
  } pbdc_state_t;
  // Control word layout.
  typedef struct packed {
    logic [23:0] rsvd;
    logic [2:0] win;
    logic hold_mode;
    logic fifo_recov;
    logic direct;
    logic pci_read;
    logic start;
  } pbdc_ctrl_t;
  // PCI pins sampled by the block.
  typedef struct packed {
    logic gnt_n;
    logic trdy_n;
    logic [31:0] ad;
  } pbdc_pin_t;
  // Side port request bundle.
  typedef struct packed {
    logic [3:0] side_write_strobe;
    logic side_read_strobe;
    logic [7:0] side_reg_addr;
  } pbdc_side_t;
endpackage : pbdc_pkg

// ===== design/pbdc_sync.sv
// Two-stage synchroniser for the sampled PCI pins.
`timescale 1ns/1ns
`default_nettype none
module pbdc_sync #(
  parameter int WIDTH = 34
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_srst, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] i_d, // Raw pin levels.
  output logic [WIDTH-1:0] o_q // Synchronised levels.
);
  logic [WIDTH-1:0] meta_ff; // First stage, read only by the second.

  // Both stages reset to the idle high level of the bus.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      meta_ff <= '1;
      o_q <= '1;
    end else begin
      meta_ff <= i_d;
      o_q <= meta_ff;
    end
  end
endmodule : pbdc_sync
`default_nettype wire

// ===== verification/pbdc_pci_far.sv
// Model of the PCI arbiter and the addressed target facing the DMA block.
`timescale 1ns/1ns
`default_nettype none
module pbdc_pci_far (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_srst, // Synchronous reset, active high.
  input wire logic i_req_n, // Bus request from the block.
  input wire logic i_irdy_n, // Initiator ready from the block.
  input wire logic i_drop, // Bench commands a grant loss.
  input wire logic [31:0] i_rdata, // Word returned on a read.
  output var pbdc_pkg::pbdc_pin_t o_pin // Grant, target ready and AD.
);
  import pbdc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Grant follows the request one cycle later unless a loss is commanded.
  // The target answers initiator ready with one-cycle target ready pulses on every other cycle.
  // A released AD bus toggles every cycle so a stale word never looks valid.
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_pin <= '{gnt_n: 1'b1, trdy_n: 1'b1, ad: 32'h0};
    end else begin
      o_pin.gnt_n <= i_req_n | i_drop;
      o_pin.trdy_n <= i_irdy_n | ~o_pin.trdy_n;
      o_pin.ad <= (i_irdy_n | ~o_pin.trdy_n) ? ~o_pin.ad : i_rdata;
    end
  end
endmodule : pbdc_pci_far
`default_nettype wire

// ===== verification/tb_pbdc_ctrl.sv
// Self-checking bench for the PCI DMA backend control block.
`timescale 1ns/1ns
`default_nettype none
`include "pbdc_defines.svh"
module tb_pbdc_ctrl;
  import pbdc_pkg::*;
  logic i_sys_clk = 1'b0; // Clock, 100 ns period.
  logic i_srst = 1'b1; // Reset, held at start.
  logic i_tgt_access = 1'b0; // Target decode hit.
  logic i_launch_hold = 1'b0; // Backend launch hold.
  logic i_rd_strobe = 1'b0; // Backend word valid.
  logic i_backend_write_ready = 1'b0; // Backend can take a word.
  logic i_side_request = 1'b0; // Side port request.
  pbdc_side_t i_side = '0; // Side strobes and address.
  logic [31:0] i_mem_data_in = 32'h0; // Backend write data.
  logic drop = 1'b0; // Commanded grant loss.
  logic [31:0] prd = 32'h0; // Word the far target returns.
  pbdc_pin_t pin; // Far side pins.
  logic o_req_n, o_frame_n, o_irdy_n, o_tgt_retry, o_mast_active; // Bus outputs.
  logic o_datapath_begin, o_datapath_finish, o_side_grant; // Backend flags.
  logic [2:0] o_window_sel; // Window in use.
  logic o_frame_oe_n, o_irdy_oe_n, o_ad_oe_n, o_be_wr_strobe; // Enables and receive strobe.
  logic [3:0] o_cbe_n; // Command and byte enables.
  logic [31:0] o_ad, o_mem_data_out, v, d; // Data words.
  logic [31:0] mdl [3]; // Model of the address, data and count registers.
  int bad_count = 0; // Mismatches seen.
  int comparisons = 0; // Comparisons made.
  always #50 i_sys_clk = ~i_sys_clk;
  pbdc_ctrl u_pbdc_ctrl (.i_sys_clk, .i_srst, .i_pin(pin), .o_req_n, .o_frame_n,
    .o_frame_oe_n, .o_irdy_n, .o_irdy_oe_n, .o_ad, .o_ad_oe_n, .o_cbe_n,
    .i_tgt_access, .o_tgt_retry, .o_mast_active, .o_datapath_begin, .o_datapath_finish,
    .o_window_sel, .o_be_wr_strobe, .i_launch_hold, .i_rd_strobe, .i_backend_write_ready,
    .i_side_request, .o_side_grant, .i_side, .i_mem_data_in, .o_mem_data_out);
  pbdc_pci_far u_pbdc_pci_far (.i_sys_clk, .i_srst, .i_req_n(o_req_n), .i_irdy_n(o_irdy_n),
    .i_drop(drop), .i_rdata(prd), .o_pin(pin));
  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks, one for flags and one for words.
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk_word
  // Side port write and read, read data taken two cycles after the strobe.
  task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] dat);
    @(posedge i_sys_clk);
    i_side <= '{side_write_strobe: s, side_read_strobe: 1'b0, side_reg_addr: a};
    i_mem_data_in <= dat;
    @(posedge i_sys_clk);
    i_side <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge i_sys_clk);
    i_side <= '{side_write_strobe: 4'h0, side_read_strobe: 1'b1, side_reg_addr: a};
    @(posedge i_sys_clk);
    i_side <= '0;
    @(posedge i_sys_clk);
    #1;
    q = o_mem_data_out;
  endtask : rd
  // Side port request, grant expected one cycle later.
  task automatic grab();
    @(posedge i_sys_clk);
    i_side_request <= 1'b1;
    @(posedge i_sys_clk);
    #1;
    chk_bit(o_side_grant, 1'b1);
  endtask : grab
  // One target hit; the retry answer shows one cycle later.
  task automatic tgt(input logic exp);
    @(posedge i_sys_clk);
    i_tgt_access <= 1'b1;
    @(posedge i_sys_clk);
    i_tgt_access <= 1'b0;
    #1;
    chk_bit(o_tgt_retry, exp);
  endtask : tgt
  // Start a transfer by a control write and play the backend with a held launch.
  task automatic dma(input logic [31:0] c, input logic [31:0] w0, input logic [31:0] w1,
                     input int aborts);
    int n;
    logic [31:0] exp_w;
    logic fetch;
    exp_w = c[2] ? mdl[1] : w0;
    wr(`PBDC_REG_CTRL, 4'hF, c);
    for (n = 1; n < 8; n++) begin
      #1;
      if (o_req_n === 1'b0) break;
      @(posedge i_sys_clk);
    end
    chk_word(32'(n), 32'(`PBDC_REQ_DLY));
    @(posedge i_sys_clk);
    i_side_request <= 1'b0;
    for (int k = 0; k <= aborts; k++) begin
      n = 0;
      while (o_mast_active !== 1'b1 && n < 60) begin
        @(posedge i_sys_clk);
        n++;
      end
      i_launch_hold <= 1'b1;
      drop <= (k < aborts);
      #1;
      chk_bit(o_datapath_begin, 1'b1);
      chk_word({29'h0, o_window_sel}, {29'h0, c[2] ? 3'h7 : c[7:5]});
      chk_word(o_ad, mdl[0]);
      chk_bit(o_ad_oe_n, 1'b0);
      chk_word(32'(o_cbe_n), c[1] ? 32'(`PBDC_CMD_MEM_RD) : 32'(`PBDC_CMD_MEM_WR));
      fetch = !c[2] && (k == 0 || !c[3]) && !c[1];
      @(posedge i_sys_clk);
      i_rd_strobe <= fetch;
      i_backend_write_ready <= c[1];
      i_mem_data_in <= (k == 0) ? w0 : w1;
      if (fetch) exp_w = (k == 0) ? w0 : w1;
      @(posedge i_sys_clk);
      i_rd_strobe <= 1'b0;
      if (k < aborts) begin
        n = 0;
        while (o_datapath_finish !== 1'b1 && n < 12) begin
          @(posedge i_sys_clk);
          #1;
          n++;
        end
        chk_bit(o_datapath_finish, 1'b1);
        chk_bit(o_req_n, 1'b0);
        @(posedge i_sys_clk);
        i_launch_hold <= 1'b0;
        drop <= 1'b0;
      end
    end
    @(posedge i_sys_clk);
    i_launch_hold <= 1'b0;
    #1;
    chk_bit(o_frame_n, 1'b1);
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk_bit(o_frame_n, 1'b0);
    chk_bit(o_frame_oe_n, 1'b0);
    chk_bit(o_irdy_oe_n, 1'b0);
    for (n = 0; o_irdy_n !== 1'b0 && n < 20; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    if (!c[1]) chk_word(o_ad, exp_w);
    chk_bit(o_ad_oe_n, c[1]);
    chk_word(32'(o_cbe_n), 32'(`PBDC_BE_ALL_N));
    for (n = 0; o_datapath_finish !== 1'b1 && n < 20; n++) begin
      @(posedge i_sys_clk);
      #1;
    end
    chk_bit(o_datapath_finish, 1'b1);
    chk_bit(o_be_wr_strobe, c[1] && !c[2]);
    if (c[1] && !c[2]) chk_word(o_mem_data_out, prd);
    @(posedge i_sys_clk);
    i_backend_write_ready <= 1'b0;
  endtask : dma
  // Print the counts and the verdict, then end the run.
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well beyond the few hundred cycles the tests take.
  initial begin
    #(3000 * 100);
    bad_count++;
    tally_and_finish();
  end
  // Main sequence: registers, held launches, aborts, direct transfers.
  initial begin
    void'($urandom(32'h54bc));
    repeat (5) @(posedge i_sys_clk);
    i_srst <= 1'b0;
    @(posedge i_sys_clk);
    #1;
    chk_bit(o_req_n, 1'b1);
    chk_bit(o_side_grant, 1'b0);
    grab();
    tgt(1'b1);
    for (int i = 0; i < 3; i++) begin
      mdl[i] = $urandom;
      wr(8'(`PBDC_REG_PCI_ADDR + 4 * i), 4'hF, mdl[i]);
    end
    v = $urandom;
    wr(`PBDC_REG_DATA, 4'h2, v);
    mdl[1][15:8] = v[15:8];
    for (int i = 0; i < 3; i++) begin
      rd(8'(`PBDC_REG_PCI_ADDR + 4 * i), d);
      chk_word(d, mdl[i]);
    end
    rd(8'h60, d);
    chk_word(d, 32'h0);
    dma(32'h000000A1, $urandom, 32'h0, 0);
    tgt(1'b0);
    grab();
    dma(32'h00000051, $urandom, $urandom, 1);
    grab();
    dma(32'h00000049, $urandom, $urandom, 1);
    grab();
    mdl[1] = $urandom;
    wr(`PBDC_REG_DATA, 4'hF, mdl[1]);
    dma(32'h00000005, 32'h0, 32'h0, 0);
    grab();
    prd = $urandom;
    dma(32'h00000007, 32'h0, 32'h0, 0);
    grab();
    rd(`PBDC_REG_DATA, d);
    chk_word(d, prd);
    grab();
    prd = $urandom;
    dma(32'h00000063, 32'h0, 32'h0, 0);
    tally_and_finish();
  end
endmodule : tb_pbdc_ctrl
`default_nettype wire
